// [verilog/ocs_top.sv]
// output clock source select: registers, source taps and output muxes
// ==========================================================
`timescale 1ns/1ps
module ocs_top
   import ocs_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // ahb-lite slave
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // asynchronous source waveforms
   input  wire logic        rate_2k_in,
   input  wire logic        rate_8k_in,
   input  wire logic        digital_rate_1_in,
   input  wire logic        digital_rate_2_in,
   input  wire logic        primary_synth_in,
   input  wire logic        secondary_synth_in,
   input  wire logic        second_primary_synth_in,
   input  wire logic        secondary_ref_in,
   input  wire logic        primary_ref_in,
   // output clocks
   output logic             out_clk_1_out,
   output logic             out_clk_3_out,
   output logic             out_clk_4_out,
   output logic             out_clk_5_out,
   output logic             out_clk_6_out
);

   localparam int OUT_NUM [0:4] = '{1, 3, 4, 5, 6};

   typedef struct packed {
      logic [OCS_N_SRC-1:0] sync_a;
      logic [OCS_N_SRC-1:0] sync_b;
      logic [7:0]           sel_1_2;
      logic [7:0]           sel_3_4;
      logic [7:0]           sel_5_6;
      logic [7:0]           config_5;
      logic                 wr_pend;
      logic [7:0]           wr_idx;
      logic [31:0]          rdata;
      logic                 ready;
      logic [OCS_N_OUT-1:0] clk_o;
   } ocs_top_s;

   ocs_top_s q, d;

   logic [OCS_N_SRC-1:0] src_raw;
   logic [OCS_N_TAP-1:0] taps;
   logic [3:0]           codes [OCS_N_OUT];
   logic [OCS_N_OUT-1:0] alts;
   ocs_tap_e             tap_sel [OCS_N_OUT];

   // ==========================================================
   // source taps
   // sources must stay below half of clk_in to be seen at all
   assign src_raw = {primary_ref_in, secondary_ref_in,
                     second_primary_synth_in, secondary_synth_in,
                     primary_synth_in, digital_rate_2_in,
                     digital_rate_1_in, rate_8k_in, rate_2k_in};

   for (genvar t = 0; t < OCS_N_TAP; t++) begin : g_tap
      if (OCS_TAP_DIV[t] == 0) begin : g_off
         assign taps[t] = 1'b0;
      end else if (OCS_TAP_DIV[t] == 1) begin : g_thru
         assign taps[t] = q.sync_b[OCS_TAP_SRC[t]];
      end else begin : g_div
         ocs_divider #(
            .DIV     (OCS_TAP_DIV[t])
         ) u_div (
            .clk_in  (clk_in),
            .rst_in  (rst_in),
            .src_in  (q.sync_b[OCS_TAP_SRC[t]]),
            .div_out (taps[t])
         );
      end
   end

   // ==========================================================
   // per-output decode
   assign codes[0] = q.sel_1_2[OCS_LO_CODE +: OCS_CODE_W];
   assign codes[1] = q.sel_3_4[OCS_LO_CODE +: OCS_CODE_W];
   assign codes[2] = q.sel_3_4[OCS_HI_CODE +: OCS_CODE_W];
   assign codes[3] = q.sel_5_6[OCS_LO_CODE +: OCS_CODE_W];
   assign codes[4] = q.sel_5_6[OCS_HI_CODE +: OCS_CODE_W];

   for (genvar o = 0; o < OCS_N_OUT; o++) begin : g_out
      // alternate bit n-1 belongs to out_clk_n
      assign alts[o] = q.config_5[OUT_NUM[o] - 1];
      ocs_decode #(
         .OUT_NUM (OUT_NUM[o])
      ) u_dec (
         .code_in (codes[o]),
         .alt_in  (alts[o]),
         .tap_out (tap_sel[o])
      );
   end

   // ==========================================================
   // bus slave, synchronisers and output registers
   always_comb begin
      logic       aphase;
      logic [7:0] idx;
      logic       in_win;
      aphase = hsel_in && htrans_in[1] && hready_in;
      idx    = haddr_in[9:2];
      in_win = (haddr_in[31:10] == 22'h0) && (haddr_in[1:0] == 2'h0);
      d = q;
      d.sync_a = src_raw;
      d.sync_b = q.sync_a;
      d.ready  = 1'b1;
      // write lands in the data phase
      if (q.wr_pend) begin
         if (q.wr_idx == OCS_IDX_SEL_1_2) begin
            d.sel_1_2 = hwdata_in[7:0];
         end else if (q.wr_idx == OCS_IDX_SEL_3_4) begin
            d.sel_3_4 = hwdata_in[7:0];
         end else if (q.wr_idx == OCS_IDX_SEL_5_6) begin
            d.sel_5_6 = hwdata_in[7:0];
         end else if (q.wr_idx == OCS_IDX_CONFIG_5) begin
            d.config_5 = hwdata_in[7:0];
         end
      end
      d.wr_pend = aphase && hwrite_in && in_win;
      d.wr_idx  = idx;
      // read sees a write finishing in the same cycle
      if (aphase && !hwrite_in) begin
         d.rdata = 32'h0000_0000;
         if (!in_win) begin
            d.rdata = 32'h0000_0000;
         end else if (idx == OCS_IDX_SEL_1_2) begin
            d.rdata = {24'h00_0000, d.sel_1_2};
         end else if (idx == OCS_IDX_SEL_3_4) begin
            d.rdata = {24'h00_0000, d.sel_3_4};
         end else if (idx == OCS_IDX_SEL_5_6) begin
            d.rdata = {24'h00_0000, d.sel_5_6};
         end else if (idx == OCS_IDX_CONFIG_5) begin
            d.rdata = {24'h00_0000, d.config_5};
         end
      end
      for (int o = 0; o < OCS_N_OUT; o++) begin
         d.clk_o[o] = taps[tap_sel[o]];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         q          <= '0;
         q.sel_1_2  <= OCS_RST_REG;
         q.sel_3_4  <= OCS_RST_REG;
         q.sel_5_6  <= OCS_RST_REG;
         q.config_5 <= OCS_RST_REG;
      end else begin
         q <= d;
      end
   end

   // every response is okay; no wait states
   assign hrdata_out    = q.rdata;
   assign hreadyout_out = q.ready;
   assign hresp_out     = 1'b0;
   assign out_clk_1_out = q.clk_o[0];
   assign out_clk_3_out = q.clk_o[1];
   assign out_clk_4_out = q.clk_o[2];
   assign out_clk_5_out = q.clk_o[3];
   assign out_clk_6_out = q.clk_o[4];
endmodule

// [verilog/ocs_pkg.sv]
// constants shared by the output clock source select block
package ocs_pkg;

   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [7:0] OCS_IDX_SEL_1_2  = 8'h60;
   localparam logic [7:0] OCS_IDX_SEL_3_4  = 8'h61;
   localparam logic [7:0] OCS_IDX_SEL_5_6  = 8'h62;
   localparam logic [7:0] OCS_IDX_CONFIG_5 = 8'h70;
   localparam logic [7:0] OCS_RST_REG      = 8'h00;

   // ==========================================================
   // field positions
   localparam int OCS_CODE_W   = 4;
   localparam int OCS_LO_CODE  = 0;
   localparam int OCS_HI_CODE  = 4;
   localparam int OCS_N_OUT    = 5;

   // ==========================================================
   // source inputs, after the synchronisers
   localparam int OCS_N_SRC    = 9;
   localparam int OCS_SRC_2K   = 0;
   localparam int OCS_SRC_8K   = 1;
   localparam int OCS_SRC_DIG1 = 2;
   localparam int OCS_SRC_DIG2 = 3;
   localparam int OCS_SRC_PRI  = 4;
   localparam int OCS_SRC_SEC  = 5;
   localparam int OCS_SRC_PRI2 = 6;
   localparam int OCS_SRC_SREF = 7;
   localparam int OCS_SRC_PREF = 8;

   // ==========================================================
   // tap numbers: one per source/divide pair
   typedef enum logic [4:0] {
      TAP_OFF  = 5'h00, TAP_2K   = 5'h01, TAP_8K   = 5'h02,
      TAP_DIG2 = 5'h03, TAP_DIG1 = 5'h04, TAP_P48  = 5'h05,
      TAP_P16  = 5'h06, TAP_P12  = 5'h07, TAP_P8   = 5'h08,
      TAP_P6   = 5'h09, TAP_P4   = 5'h0A, TAP_P2   = 5'h0B,
      TAP_P1   = 5'h0C, TAP_P64  = 5'h0D, TAP_S64  = 5'h0E,
      TAP_S48  = 5'h0F, TAP_S16  = 5'h10, TAP_S8   = 5'h11,
      TAP_S4   = 5'h12, TAP_S2   = 5'h13, TAP_S20  = 5'h14,
      TAP_S12  = 5'h15, TAP_S10  = 5'h16, TAP_S5   = 5'h17,
      TAP_S1   = 5'h18, TAP_Q10  = 5'h19, TAP_Q5   = 5'h1A,
      TAP_Q2   = 5'h1B, TAP_Q1   = 5'h1C, TAP_SREF = 5'h1D,
      TAP_PREF = 5'h1E, TAP_NONE = 5'h1F
   } ocs_tap_e;

   localparam int OCS_N_TAP = 32;
   // divide 0 means tied low, 1 means straight through
   localparam int OCS_TAP_SRC [0:31] = '{
      0, 0, 1, 3, 2, 4, 4, 4, 4, 4, 4, 4, 4, 4, 5, 5,
      5, 5, 5, 5, 5, 5, 5, 5, 5, 6, 6, 6, 6, 7, 8, 0};
   localparam int OCS_TAP_DIV [0:31] = '{
      0, 1, 1, 1, 1, 48, 16, 12, 8, 6, 4, 2, 1, 64, 64, 48,
      16, 8, 4, 2, 20, 12, 10, 5, 1, 10, 5, 2, 1, 1, 1, 0};

endpackage

// [verilog/ocs_divider.sv]
// edge-counting divider for one source tap
`timescale 1ns/1ps
module ocs_divider
   import ocs_pkg::*;
#(
   parameter int DIV = 2
) (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic src_in,
   output logic      div_out
);
   localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] HALF = CW'(DIV / 2);

   typedef struct packed {
      logic          prev;
      logic [CW-1:0] cnt;
      logic          out;
   } ocs_div_s;

   ocs_div_s q, d;

   // ==========================================================
   // count rising edges; odd ratios give a short high phase
   always_comb begin
      d = q;
      d.prev = src_in;
      if (src_in && !q.prev) begin
         if (q.cnt == LAST) begin
            d.cnt = '0;
         end else begin
            d.cnt = q.cnt + 1'b1;
         end
         d.out = (d.cnt < HALF);
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign div_out = q.out;
endmodule

// [verilog/ocs_decode.sv]
// per-output decode of selection code and alternate bit into a tap
`timescale 1ns/1ps
module ocs_decode
   import ocs_pkg::*;
#(
   parameter int OUT_NUM = 3
) (
   input  wire logic [3:0] code_in,
   input  wire logic       alt_in,
   output ocs_tap_e        tap_out
);
   always_comb begin
      tap_out = TAP_OFF;
      if (!alt_in) begin
         case (code_in)
            4'h1: tap_out = TAP_2K;
            4'h2: tap_out = TAP_8K;
            4'h3: tap_out = (OUT_NUM == 6) ? TAP_P2 : TAP_DIG2;
            4'h4: tap_out = TAP_DIG1;
            4'h5: tap_out = (OUT_NUM == 6) ? TAP_P1 : TAP_P48;
            4'h6: tap_out = TAP_P16;
            4'h7: tap_out = TAP_P12;
            4'h8: tap_out = TAP_P8;
            4'h9: tap_out = TAP_P6;
            4'hA: tap_out = TAP_P4;
            4'hB: begin
               if (OUT_NUM == 4 || OUT_NUM == 5) begin
                  tap_out = TAP_S2;
               end else begin
                  tap_out = TAP_S64;
               end
            end
            4'hC: tap_out = TAP_S48;
            4'hD: tap_out = TAP_S16;
            4'hE: tap_out = TAP_S8;
            4'hF: tap_out = TAP_S4;
            default: tap_out = TAP_OFF;
         endcase
      end else begin
         case (code_in)
            4'h7: tap_out = TAP_SREF;
            4'h8: tap_out = TAP_PREF;
            default: begin
               if (OUT_NUM == 4 || OUT_NUM == 5) begin
                  case (code_in)
                     4'h1: tap_out = TAP_P2;
                     4'h2: tap_out = TAP_P1;
                     4'h3: tap_out = TAP_S10;
                     4'h4: tap_out = TAP_Q10;
                     4'h5: tap_out = TAP_Q2;
                     4'h6: tap_out = TAP_Q1;
                     default: tap_out = TAP_OFF;
                  endcase
               end else if (OUT_NUM == 6) begin
                  case (code_in)
                     4'h1: tap_out = TAP_S5;
                     4'h2: tap_out = TAP_S2;
                     4'h3: tap_out = TAP_S1;
                     4'h4: tap_out = TAP_Q5;
                     4'h5: tap_out = TAP_Q2;
                     4'h6: tap_out = TAP_Q1;
                     default: tap_out = TAP_OFF;
                  endcase
               end else begin
                  case (code_in)
                     4'h1: tap_out = TAP_P64;
                     4'h2: tap_out = TAP_S20;
                     4'h3: tap_out = TAP_S12;
                     4'h4: tap_out = TAP_S10;
                     4'h5: tap_out = (OUT_NUM == 1) ? TAP_Q10 : TAP_S5;
                     4'h6: tap_out = (OUT_NUM == 1) ? TAP_Q5 : TAP_S2;
                     default: tap_out = TAP_OFF;
                  endcase
               end
            end
         endcase
      end
   end
endmodule

// [sim/ocs_chk.sv]
// assertion checker for the output clock source select block
`timescale 1ns/1ps
module ocs_chk
   import ocs_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hrdata_out,
   input  wire logic        hreadyout_out,
   input  wire logic        hresp_out,
   input  wire logic        out_clk_1_out,
   input  wire logic        out_clk_3_out,
   input  wire logic        out_clk_4_out,
   input  wire logic        out_clk_5_out,
   input  wire logic        out_clk_6_out
);
   // ==========================================================
   // bus-side shadow of the 3/4 and 5/6 selection registers
   logic       take;
   logic       wr_q;
   logic       rd_q;
   logic [7:0] a_q;
   logic [7:0] r34_q;
   logic [7:0] r56_q;
   logic [1:0] age_q;
   assign take = hsel_in && htrans_in[1] && hready_in;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         a_q   <= 8'h00;
         r34_q <= 8'h00;
         r56_q <= 8'h00;
         age_q <= 2'h0;
      end else begin
         wr_q <= take && hwrite_in;
         rd_q <= take && !hwrite_in;
         a_q  <= take ? haddr_in[9:2] : a_q;
         if (wr_q && a_q == OCS_IDX_SEL_3_4) r34_q <= hwdata_in[7:0];
         if (wr_q && a_q == OCS_IDX_SEL_5_6) r56_q <= hwdata_in[7:0];
         // output may lag a write by two cycles, so wait three
         age_q <= wr_q ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   chk_bus_ready: assert property (!$past(rst_in) |-> hreadyout_out)
      else $error("hreadyout low after reset");
   chk_resp_okay: assert property (hresp_out == 1'b0)
      else $error("response not okay");
   chk_reset_low: assert property ($fell(rst_in) |->
      !(out_clk_1_out || out_clk_3_out || out_clk_4_out ||
        out_clk_5_out || out_clk_6_out) [*3])
      else $error("output clock active after reset");
   chk_read_34: assert property (rd_q && a_q == OCS_IDX_SEL_3_4 |->
      hrdata_out == {24'h000000, r34_q})
      else $error("wrong read data for select 3/4");
   chk_read_56: assert property (rd_q && a_q == OCS_IDX_SEL_5_6 |->
      hrdata_out == {24'h000000, r56_q})
      else $error("wrong read data for select 5/6");
   chk_off_3: assert property (age_q == 2'h3 && r34_q[3:0] == 4'h0
      |-> !out_clk_3_out)
      else $error("out_clk_3 runs with code zero");
   chk_off_4: assert property ((r34_q[7:4] == 4'h0) [*3]
      |-> !out_clk_4_out)
      else $error("out_clk_4 runs with code zero");
   chk_off_5: assert property (age_q == 2'h3 && r56_q[3:0] == 4'h0
      |-> !out_clk_5_out)
      else $error("out_clk_5 runs with code zero");
   chk_off_6: assert property ((r56_q[7:4] == 4'h0) [*3]
      |-> !out_clk_6_out)
      else $error("out_clk_6 runs with code zero");
endmodule

bind ocs_top ocs_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
   .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
   .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
   .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
   .hresp_out(hresp_out), .out_clk_1_out(out_clk_1_out),
   .out_clk_3_out(out_clk_3_out), .out_clk_4_out(out_clk_4_out),
   .out_clk_5_out(out_clk_5_out), .out_clk_6_out(out_clk_6_out));

// [sim/testbench.sv]
// self-checking bench for the output clock source select block
`timescale 1ns/1ps
module testbench
   import ocs_pkg::*;
;
   logic        clk_in, rst_in, hsel, hwrite, hrdy, hresp;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic [8:0]  src;
   logic [4:0]  oc;
   int          failures, n_tests;
   // source periods in clock cycles, all even so edges miss clk_in
   localparam int PER [0:8] = '{4, 6, 8, 10, 12, 14, 16, 18, 20};
   localparam int SH [0:4] = '{0, 8, 12, 16, 20};
   localparam int AB [0:4] = '{0, 2, 3, 4, 5};
   // case: output, alt, code, source, divide
   localparam logic [23:0] CS [0:43] = '{
      24'h101001, 24'h202101, 24'h003301, 24'h104201,
      24'h105430, 24'h206410, 24'h10740C, 24'h208408,
      24'h109406, 24'h20A404, 24'h30B502,
      24'h20B502, 24'h20C530, 24'h20F504,
      24'h10B540, 24'h00D510, 24'h40E508,
      24'h403402, 24'h405401, 24'h010000, 24'h400000,
      24'h211402, 24'h212401, 24'h21350A,
      24'h21460A, 24'h215602, 24'h216601,
      24'h017701, 24'h418801,
      24'h111440, 24'h112514, 24'h11350C,
      24'h11450A, 24'h115505, 24'h116502,
      24'h01560A, 24'h016605, 24'h012514,
      24'h411505, 24'h412502, 24'h413501,
      24'h414605, 24'h415602, 24'h416601};
   ocs_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hrdy),
      .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
      .rate_2k_in(src[0]), .rate_8k_in(src[1]),
      .digital_rate_1_in(src[2]), .digital_rate_2_in(src[3]),
      .primary_synth_in(src[4]), .secondary_synth_in(src[5]),
      .second_primary_synth_in(src[6]), .secondary_ref_in(src[7]),
      .primary_ref_in(src[8]), .out_clk_1_out(oc[0]),
      .out_clk_3_out(oc[1]), .out_clk_4_out(oc[2]),
      .out_clk_5_out(oc[3]), .out_clk_6_out(oc[4]));
   // ==========================================================
   // clock and sources
   always #5 clk_in = ~clk_in;
   for (genvar g = 0; g < 9; g++) begin : g_src
      logic s = 1'b0;
      always #(5 * PER[g]) s = ~s;
      assign src[g] = s;
   end
   // ==========================================================
   // tasks
   task automatic check(input string nm, input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wait_rdy;
      @(posedge clk_in);
      // zero wait states: a stall counts once, then is waited out
      check("hready", {31'h0, hrdy}, 32'h1);
      while (hrdy !== 1'b1) begin
         @(posedge clk_in);
      end
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic bus(input logic [7:0] ix, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {22'h0, ix, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      logic [31:0] x;
      bus(ix, 1'b1, {24'h0, d}, x);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] ix, e);
      logic [31:0] x;
      bus(ix, 1'b0, 32'h0, x);
      check(nm, x, {24'h0, e});
   endtask
   // period between second and third rise; 0 if it never runs
   task automatic meas(input int o, output int p);
      int   t, r, t1;
      logic pv, v;
      r = 0;
      t = 0;
      t1 = 0;
      pv = 1'b1;
      p = 0;
      while (r < 3 && t < 3200) begin
         @(posedge clk_in);
         t++;
         v = oc[o];
         if (v === 1'b1 && pv === 1'b0) begin
            r++;
            if (r == 2) t1 = t;
            if (r == 3) p = t - t1;
         end
         pv = v;
      end
   endtask
   // ==========================================================
   // tests
   initial begin
      logic [23:0] v, c;
      int          p, o;
      clk_in = 1'b0;
      rst_in = 1'b1;
      {hsel, hwrite, htrans} = 4'h0;
      {haddr, hwdata, failures, n_tests} = '0;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      check("reset", {27'h0, oc}, 32'h0);
      rdchk("sel34", OCS_IDX_SEL_3_4, 8'h00);
      rdchk("sel56", OCS_IDX_SEL_5_6, 8'h00);
      wr(8'h7F, 8'hA5);
      rdchk("unmapped", 8'h7F, 8'h00);
      wr(OCS_IDX_SEL_3_4, 8'h5A);
      wr(OCS_IDX_SEL_5_6, 8'hC3);
      rdchk("sel34", OCS_IDX_SEL_3_4, 8'h5A);
      rdchk("sel56", OCS_IDX_SEL_5_6, 8'hC3);
      $display("register test done");
      for (int i = 0; i < 44; i++) begin
         c = CS[i];
         o = c[23:20];
         v = 24'h0;
         v[SH[o] +: 4] = c[15:12];
         wr(OCS_IDX_SEL_1_2, v[7:0]);
         wr(OCS_IDX_SEL_3_4, v[15:8]);
         wr(OCS_IDX_SEL_5_6, v[23:16]);
         wr(OCS_IDX_CONFIG_5, 8'({7'h0, c[16]} << AB[o]));
         rdchk("sel34", OCS_IDX_SEL_3_4, v[15:8]);
         rdchk("sel56", OCS_IDX_SEL_5_6, v[23:16]);
         meas(o, p);
         check("period", 32'(p), 32'(PER[c[11:8]] * c[7:0]));
         if (c[7:0] == 8'h00) begin
            check("off", {31'h0, oc[o]}, 32'h0);
         end
         $display("case %0d period %0d done", i, p);
      end
      final_report();
   end
   // tests need about 25k cycles; 50k leaves room for slow taps
   initial begin
      #500000;
      failures++;
      final_report();
   end
endmodule
